// >>> gpc_port.v
// gpc_port.v - four 8-bit gpio ports with pin change flags per port group
// assumes a byte register port, an asynchronous pad ring and a core that
// acknowledges each group vector it takes
`timescale 1ns/1ns
`default_nettype none
`include "gpc_regs.vh"

// Contract
// - enabled pin change sets its group flag
// - flag, global and group enable request vector
// - flag clears on service or write one
// - mask bit enables detection per pin
// - output, direction rw; pin input readable
// - writing one to input toggles output
// - pull-up disable kills every pull-up
// - direction one output, zero input
// - input with output one pulls up
// - output drives data bit, pull-up ignored
// - reset tri-states every pin immediately
// - single bit changes leave others intact
// - override on one pin spares others
// - disabled pull-up gives high impedance input
// - pin level readable in any direction
// - pin input synchronised by two stages
module gpc_port (
  // clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // interrupt handshake with the core
  input wire global_irq_enable_i,
  input wire [3:0] irq_ack_i,
  output wire [3:0] irq_req_o,
  // peripheral override, one bit per pin
  input wire [31:0] ovr_en_i,
  input wire [31:0] ovr_oe_i,
  input wire [31:0] ovr_val_i,
  // pads
  input wire [31:0] pad_i,
  output wire [31:0] pad_o,
  output wire [31:0] pad_oe_o,
  output wire [31:0] pad_pullup_o
);

  // address of one register of a port triplet
  function [7:0] port_addr;
    input [1:0] idx;
    input [7:0] ofs;
    begin
      port_addr = `GPC_PORT_BASE + (`GPC_PORT_STRIDE * {6'h00, idx}) + ofs;
    end
  endfunction

  // address of a group mask register
  function [7:0] mask_addr;
    input [1:0] idx;
    begin
      case (idx)
        2'd0: mask_addr = `GPC_ADDR_MASK0;
        2'd1: mask_addr = `GPC_ADDR_MASK1;
        2'd2: mask_addr = `GPC_ADDR_MASK2;
        default: mask_addr = `GPC_ADDR_MASK3;
      endcase
    end
  endfunction

  // software state
  reg [31:0] port_output_reg_r; // output data bits, all ports
  reg [31:0] port_output_reg_nxt;
  reg [31:0] port_direction_reg_r; // direction bits, one means output
  reg [31:0] port_direction_reg_nxt;
  reg [31:0] group_pin_mask_r; // masks of groups 3..0 packed
  reg [31:0] group_pin_mask_nxt;
  reg [3:0] change_group_control_r; // group enables
  reg [3:0] change_group_flags_r; // group flags
  reg [3:0] change_group_flags_nxt;
  reg global_pullup_disable_r; // pull-up disable bit
  reg [7:0] rdata_nxt; // read mux result
  // change detection
  wire [31:0] pin_sync; // synchronised pad levels
  reg [31:0] pin_prev_r; // levels one clock earlier
  reg [3:0] group_hit; // group saw an enabled change
  reg [3:0] flag_clr; // clears from software and service
  // loop indices, one per process so no variable has two drivers
  integer k_wr; // next-state loop
  integer k_hit; // change detection loop
  integer k_rd; // read mux loop
  // synchroniser fill tracking after reset
  reg [1:0] sync_fill_r; // clocks since reset, saturates at the fill count
  wire sync_full; // chain and previous sample both hold pad levels
  // decoded write strobes
  wire wr_ctrl; // write to the group enable register
  wire wr_flags; // write to the flag register
  wire wr_core; // write to the core control register

  // synchroniser for all pads
  // pad capture
  gpc_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(pad_i),
    .sync_o(pin_sync)
  );

  // next state of port and mask registers
  // each write replaces or toggles one byte; bytes of other ports keep their value
  always @* begin
    port_output_reg_nxt = port_output_reg_r;
    port_direction_reg_nxt = port_direction_reg_r;
    group_pin_mask_nxt = group_pin_mask_r;
    for (k_wr = 0; k_wr < 4; k_wr = k_wr + 1) begin
      if (reg_wr_i) begin
        if (reg_addr_i == port_addr(k_wr[1:0], `GPC_OFS_PIN)) begin
          // ones invert, zeros leave the output bit alone
          port_output_reg_nxt[8*k_wr +: 8] = port_output_reg_r[8*k_wr +: 8] ^ reg_wdata_i;
        end
        if (reg_addr_i == port_addr(k_wr[1:0], `GPC_OFS_OUT)) begin
          port_output_reg_nxt[8*k_wr +: 8] = reg_wdata_i;
        end
        if (reg_addr_i == port_addr(k_wr[1:0], `GPC_OFS_DIR)) begin
          // one makes the pin an output
          port_direction_reg_nxt[8*k_wr +: 8] = reg_wdata_i;
        end
        if (reg_addr_i == mask_addr(k_wr[1:0])) begin
          // one arms change detection on that pin
          group_pin_mask_nxt[8*k_wr +: 8] = reg_wdata_i;
        end
      end
    end
  end

  // change detection per group
  // a group only looks once the synchroniser has refilled after reset
  always @* begin
    group_hit = 4'h0;
    for (k_hit = 0; k_hit < 4; k_hit = k_hit + 1) begin
      group_hit[k_hit] = sync_full & change_group_control_r[k_hit]
                         & (|((pin_sync[8*k_hit +: 8] ^ pin_prev_r[8*k_hit +: 8])
                              & group_pin_mask_r[8*k_hit +: 8]));
    end
  end

  // flag clears and next flag value
  always @* begin
    flag_clr = irq_ack_i;
    if (wr_flags) begin
      // ones in the written byte clear, zeros leave the flag alone
      flag_clr = flag_clr | reg_wdata_i[`GPC_GRP_MSB:0];
    end
    // set wins over clear
    // a change in the same clock as its clear must not be lost
    change_group_flags_nxt = (change_group_flags_r & ~flag_clr) | group_hit;
  end

  // read mux
  // unmapped addresses read zero, so software never sees a floating byte
  always @* begin
    rdata_nxt = `GPC_RST_BYTE;
    for (k_rd = 0; k_rd < 4; k_rd = k_rd + 1) begin
      if (reg_addr_i == port_addr(k_rd[1:0], `GPC_OFS_PIN)) begin
        // synchronised pad level, also for pins driven as outputs
        rdata_nxt = pin_sync[8*k_rd +: 8];
      end
      if (reg_addr_i == port_addr(k_rd[1:0], `GPC_OFS_DIR)) begin
        rdata_nxt = port_direction_reg_r[8*k_rd +: 8];
      end
      if (reg_addr_i == port_addr(k_rd[1:0], `GPC_OFS_OUT)) begin
        rdata_nxt = port_output_reg_r[8*k_rd +: 8];
      end
      if (reg_addr_i == mask_addr(k_rd[1:0])) begin
        rdata_nxt = group_pin_mask_r[8*k_rd +: 8];
      end
    end
    // group registers read zero in bits 7:4, core register reads zero except the pull-up disable bit
    if (reg_addr_i == `GPC_ADDR_CTRL) begin
      rdata_nxt = {4'h0, change_group_control_r};
    end
    if (reg_addr_i == `GPC_ADDR_FLAGS) begin
      rdata_nxt = {4'h0, change_group_flags_r};
    end
    if (reg_addr_i == `GPC_ADDR_CORE) begin
      rdata_nxt = `GPC_RST_BYTE;
      rdata_nxt[`GPC_PUD_BIT] = global_pullup_disable_r;
    end
  end

  // register file and change state
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      // every pin an input without pull-up, no group armed
      port_output_reg_r <= `GPC_RST_WORD;
      port_direction_reg_r <= `GPC_RST_WORD;
      group_pin_mask_r <= `GPC_RST_WORD;
      change_group_control_r <= `GPC_RST_GRP;
      change_group_flags_r <= `GPC_RST_GRP;
      global_pullup_disable_r <= 1'b0;
      pin_prev_r <= `GPC_RST_WORD;
    end else begin
      port_output_reg_r <= port_output_reg_nxt;
      port_direction_reg_r <= port_direction_reg_nxt;
      group_pin_mask_r <= group_pin_mask_nxt;
      change_group_flags_r <= change_group_flags_nxt;
      pin_prev_r <= pin_sync;
      // group enable register
      if (wr_ctrl) begin
        change_group_control_r <= reg_wdata_i[`GPC_GRP_MSB:0];
      end
      // core control, only the pull-up disable bit is kept
      if (wr_core) begin
        global_pullup_disable_r <= reg_wdata_i[`GPC_PUD_BIT];
      end
    end
  end

  // read data register
  // the byte stands only in the cycle after the strobe and reads zero otherwise,
  // so a stale value cannot be mistaken for a fresh answer
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      // nothing to show in reset
      reg_rdata_o <= `GPC_RST_BYTE;
    end else if (reg_rd_i) begin
      // capture the byte addressed by the strobe
      reg_rdata_o <= rdata_nxt;
    end else begin
      // idle bus reads zero
      reg_rdata_o <= `GPC_RST_BYTE;
    end
  end

  // decode of the single-register writes
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `GPC_ADDR_CTRL);
  assign wr_flags = reg_wr_i && (reg_addr_i == `GPC_ADDR_FLAGS);
  assign wr_core = reg_wr_i && (reg_addr_i == `GPC_ADDR_CORE);

  // the synchroniser and the previous sample restart from zero in reset;
  // until both hold real pad levels a pad sitting at one would look like a
  // change, so detection waits for the fill count
  assign sync_full = (sync_fill_r == `GPC_SYNC_FILL);

  // fill counter, saturating at the fill count
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      // restart the fill after every reset
      sync_fill_r <= `GPC_RST_FILL;
    end else if (!sync_full) begin
      // one more clock of real pad samples
      sync_fill_r <= sync_fill_r + 2'd1;
    end
  end

  assign irq_req_o = change_group_flags_r & change_group_control_r
                     & {4{global_irq_enable_i}};

  // pad drive: override replaces only its own pin
  // per pin override
  assign pad_o = (ovr_en_i & ovr_val_i) | (~ovr_en_i & port_output_reg_r);

  assign pad_oe_o = ((ovr_en_i & ovr_oe_i) | (~ovr_en_i & port_direction_reg_r))
                    & {32{~sys_rst_i}};

  // pull-up only on inputs with data one and no disable
  // input pull-up
  assign pad_pullup_o = ~port_direction_reg_r & port_output_reg_r
                        & {32{~global_pullup_disable_r}} & ~ovr_en_i
                        & {32{~sys_rst_i}};

endmodule // gpc_port

`default_nettype wire

// >>> gpc_regs.vh
// gpc_regs.vh - register map, field positions and reset values of the gpio port block
// assumes byte-wide registers on an 8-bit address space
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

// port register triplets: base of port 0, stride between ports
`define GPC_PORT_BASE 8'h20
`define GPC_PORT_STRIDE 8'h03
// offsets inside one triplet
`define GPC_OFS_PIN 8'h00
`define GPC_OFS_DIR 8'h01
`define GPC_OFS_OUT 8'h02

// pin change group registers
`define GPC_ADDR_MASK0 8'h6B
`define GPC_ADDR_MASK1 8'h6C
`define GPC_ADDR_MASK2 8'h6D
`define GPC_ADDR_MASK3 8'h73
`define GPC_ADDR_CTRL 8'h68
`define GPC_ADDR_FLAGS 8'h3B

// core control register and its pull-up disable bit
`define GPC_ADDR_CORE 8'h55
`define GPC_PUD_BIT 4

// group enables and flags sit in bits 3:0
`define GPC_GRP_MSB 3

// clocks after reset until synchroniser and previous sample hold pad levels
`define GPC_SYNC_FILL 2'd3

// reset values
`define GPC_RST_BYTE 8'h00
`define GPC_RST_WORD 32'h0000_0000
`define GPC_RST_GRP 4'h0
`define GPC_RST_FILL 2'd0

`endif

// >>> gpc_sync.v
// gpc_sync.v - two-stage synchroniser for the 32 pad inputs
// assumes pads are asynchronous to ref_clk_i
`timescale 1ns/1ns
`default_nettype none

module gpc_sync (
  // clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  // raw pads in, synchronised levels out
  input wire [31:0] async_i,
  output reg [31:0] sync_o
);

  // first stage, read only by the second stage
  reg [31:0] meta_r;

  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      meta_r <= `GPC_RST_WORD;
      sync_o <= `GPC_RST_WORD;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // gpc_sync

`default_nettype wire

// >>> gpc_pins.sv
// pad ring model: design drive first, then board drivers, then pull-ups
// assumes the bench sets xen_i/xv_i; an undriven pad without pull-up shows a moving pattern
`timescale 1ns/1ns
`default_nettype none
module gpc_pins (
  // clock for the floating pattern
  input wire logic clk_i,
  // design side and board side
  input wire logic [31:0] drv_i,
  input wire logic [31:0] oe_i,
  input wire logic [31:0] pu_i,
  input wire logic [31:0] xen_i,
  input wire logic [31:0] xv_i,
  output logic [31:0] lvl_o
);
  logic flip = 1'b0; // flips every cycle so a float never looks stable
  always @(posedge clk_i) begin
    flip <= ~flip;
  end
  assign lvl_o = (oe_i & drv_i) | (~oe_i & xen_i & xv_i)
    | (~oe_i & ~xen_i & (pu_i | {16{flip, ~flip}}));
endmodule // gpc_pins
`default_nettype wire

// >>> gpc_port_props.sv
// assertions on the gpc_port ports
// assumes a bind from the bench and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module gpc_port_props (
  // clock, reset, register writes
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // interrupt handshake
  input wire logic global_irq_enable_i,
  input wire logic [3:0] irq_ack_i,
  input wire logic [3:0] irq_req_o,
  // pads
  input wire logic [31:0] ovr_en_i,
  input wire logic [31:0] pad_i,
  input wire logic [31:0] pad_o,
  input wire logic [31:0] pad_oe_o,
  input wire logic [31:0] pad_pullup_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // toggle request on pin 0
  wire logic tog0 = reg_wr_i && reg_addr_i == 8'h20 && reg_wdata_i[0];
  a_rst_tristate: assert property (disable iff (1'b0)
    sys_rst_i |-> !(pad_oe_o | pad_pullup_o)) else $error("pad active in reset");
  a_req_global: assert property (|irq_req_o |-> global_irq_enable_i)
    else $error("request without global enable");
  a_req_clear: assert property ($fell(irq_req_o[1]) |->
    $past(irq_ack_i[1] || reg_wr_i) || $fell(global_irq_enable_i)) else $error("flag lost");
  a_pull_drive: assert property (!(pad_oe_o & pad_pullup_o))
    else $error("pull-up on driven pad");
  a_pull_ovr: assert property (!(ovr_en_i & pad_pullup_o))
    else $error("pull-up on override pad");
  a_toggle_out: assert property (tog0 && !ovr_en_i[0] ##1 !ovr_en_i[0] |->
    pad_o[0] != $past(pad_o[0])) else $error("no toggle");
  a_pud_off: assert property (reg_wr_i && reg_addr_i == 8'h55 && reg_wdata_i[4]
    |=> pad_pullup_o == 32'h0000_0000) else $error("pull-up kept");
  a_flag_cause: assert property ($rose(irq_req_o[1]) |->
    $past(pad_i[15:8], 3) != $past(pad_i[15:8], 5) || $past(reg_wr_i)
    || $rose(global_irq_enable_i)) else $error("flag without change");
  c_flag: cover property ($rose(irq_req_o[1]));
  c_ack: cover property (irq_ack_i[1] && irq_req_o[1]);
  c_pud: cover property (reg_wr_i && reg_addr_i == 8'h55);
endmodule // gpc_port_props
`default_nettype wire

// >>> gpc_port_tb.sv
// self-checking bench for gpc_port with a pad model and a bound checker
// assumes gpc_port, gpc_pins and gpc_port_props compile first
`timescale 1ns/1ns
`default_nettype none
module gpc_port_tb;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ge = 1'b0;
  logic [7:0] a = 8'h00, wd = 8'h00, rdat, k, d, t;
  logic [3:0] ack = 4'h0, req;
  logic [31:0] ov = 32'h0, xen = 32'hFFFF_FFFF, xv = 32'h0, po, oe, pu, pin, px;
  logic [31:0] m_dir = 32'h0, m_out = 32'h0; // model of the port registers
  logic m_pud = 1'b0;
  logic [7:0] ra [8] = '{8'h6B, 8'h6C, 8'h6D, 8'h73, 8'h68, 8'h3B, 8'h55, 8'h10};
  int n_mismatch = 0, n_compared = 0, cyc = 0, seed = 32'h6259;
  always #5 clk = ~clk;
  gpc_port dut_u (.ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(a), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .global_irq_enable_i(ge),
    .irq_ack_i(ack), .irq_req_o(req), .ovr_en_i(ov), .ovr_oe_i(ov), .ovr_val_i(ov),
    .pad_i(pin), .pad_o(po), .pad_oe_o(oe), .pad_pullup_o(pu));
  gpc_pins pins_u (.clk_i(clk), .drv_i(po), .oe_i(oe), .pu_i(pu), .xen_i(xen), .xv_i(xv),
    .lvl_o(pin));
  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // one write, then an idle cycle
  task automatic wr8(logic [7:0] ad, logic [7:0] dt);
    a <= ad;
    wd <= dt;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // one read, data sampled in the following cycle
  task automatic rd8(logic [7:0] ad, logic [7:0] e, string n);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(n, {24'h0, e}, {24'h0, rdat});
  endtask
  task automatic chk_pads();
    chk("pad_oe", m_dir | ov, oe);
    chk("pad_o", m_out | ov, po);
    chk("pad_pullup", ~m_dir & m_out & ~ov & ~{32{m_pud}}, pu);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    #1;
    chk("pads_in_reset", 32'h0, oe | pu);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 12; i++) rd8(8'h20 + 8'(i), 8'h00, "reset_value");
    foreach (ra[i]) rd8(ra[i], 8'h00, "reset_value");
    ov <= 32'h8000_0000;
    for (int i = 0; i < 12; i++) begin
      k = 8'(i % 4);
      d = 8'($random(seed));
      t = 8'($random(seed));
      wr8(8'h21 + 8'd3 * k, d);
      wr8(8'h22 + 8'd3 * k, t);
      m_dir[8*k+:8] = d;
      m_out[8*k+:8] = t;
      t = 8'($random(seed));
      wr8(8'h20 + 8'd3 * k, t);
      m_out[8*k+:8] ^= t;
      xv <= $random(seed);
      repeat (3) @(posedge clk);
      chk_pads();
      px = ((m_dir | ov) & (m_out | ov)) | (~(m_dir | ov) & xv);
      rd8(8'h21 + 8'd3 * k, m_dir[8*k+:8], "dir");
      rd8(8'h22 + 8'd3 * k, m_out[8*k+:8], "out");
      rd8(8'h20 + 8'd3 * k, px[8*k+:8], "pin");
    end
    wr8(8'h24, 8'h00);
    m_dir[15:8] = 8'h00;
    wr8(8'h6C, 8'h0F);
    wr8(8'h68, 8'h02);
    wr8(8'h3B, 8'h0F);
    ge <= 1'b1;
    xv <= xv ^ 32'h0000_1000;
    repeat (5) @(posedge clk);
    chk("req_unmasked", 32'h0, {28'h0, req});
    xv <= xv ^ 32'h0000_0200;
    repeat (5) @(posedge clk);
    chk("req", 32'h2, {28'h0, req});
    rd8(8'h3B, 8'h02, "flags");
    ge <= 1'b0;
    @(posedge clk);
    chk("req_global", 32'h0, {28'h0, req});
    ge <= 1'b1;
    ack <= 4'h2;
    @(posedge clk);
    ack <= 4'h0;
    @(posedge clk);
    chk("req_ack", 32'h0, {28'h0, req});
    xv <= xv ^ 32'h0000_0200;
    repeat (5) @(posedge clk);
    chk("req_again", 32'h2, {28'h0, req});
    wr8(8'h3B, 8'h02);
    rd8(8'h3B, 8'h00, "flags_w1c");
    wr8(8'h21, 8'h00);
    wr8(8'h22, 8'hF0);
    m_dir[7:0] = 8'h00;
    m_out[7:0] = 8'hF0;
    xen <= 32'hFFFF_FF0F;
    xv <= 32'h0;
    wr8(8'h55, 8'h10);
    m_pud = 1'b1;
    chk_pads();
    rd8(8'h55, 8'h10, "pud");
    wr8(8'h55, 8'h00);
    m_pud = 1'b0;
    repeat (3) @(posedge clk);
    chk_pads();
    rd8(8'h20, 8'hF0, "pin_pullup");
    // pin 16 moves only through legal intermediate states;
    // output is cleared before direction so the cleanup is legal too
    wr8(8'h27, 8'h00);
    wr8(8'h28, 8'h00);
    m_dir[23:16] = 8'h00;
    m_out[23:16] = 8'h00;
    wr8(8'h28, 8'h01);
    m_out[16] = 1'b1;
    chk_pads();
    wr8(8'h27, 8'h01);
    m_dir[16] = 1'b1;
    chk_pads();
    wr8(8'h28, 8'h00);
    m_out[16] = 1'b0;
    wr8(8'h27, 8'h00);
    m_dir[16] = 1'b0;
    chk_pads();
    wr8(8'h28, 8'h01);
    m_out[16] = 1'b1;
    chk_pads();
    wr8(8'h20, 8'h01);
    m_out[0] = ~m_out[0];
    chk_pads();
    rst <= 1'b1;
    @(posedge clk);
    chk("pads_mid_reset", 32'h0, oe | pu);
    stop_test();
  end
endmodule // gpc_port_tb
bind gpc_port gpc_port_props u_props (.*);
`default_nettype wire
